// ### logic/fir_cfg.svh
// Constants for the dual FIR configuration register bank
`ifndef FIR_CFG_SVH
`define FIR_CFG_SVH
`define ADDR_STRUCT 9'h000
`define ADDR_FORMAT 9'h001
`define ADDR_COEF_FLAG 8
`define ADDR_FILTER_BIT 2
`define ADDR_SET_LSB 3
`define ADDR_BANK_LSB 0
`define CFG_RESET_VAL 10'h000
`define INT_RESET_CYCLES 3'h6
`define F0_DECIM_LSB 0
`define F0_DUAL 4
`define F0_ODD_SYM 5
`define F0_EVEN_A 6
`define F0_EVEN_B 7
`define F0_B_OWN_IN 8
`define F0_INTERLEAVE 9
`define F1_A_DATA_TC 0
`define F1_A_COEF_TC 1
`define F1_B_DATA_TC 2
`define F1_B_COEF_TC 3
`define F1_REV_DIS 4
`define F1_ROUND_LSB 5
`define F1_ROUND_DIS 9
`define COEF_SETS 32
`define COEF_PER_SET 8
`endif

// ### logic/fir_pkg.sv
// Types shared by the configuration register bank
package fir_pkg;
    typedef logic [9:0] cfg_word_t;
    typedef logic [8:0] cfg_addr_t;
    typedef logic [4:0] coef_sel_t;
    typedef logic [79:0] coef_set_t;
    typedef enum logic [1:0] {
        RUN_ST = 2'h1,
        HOLD_ST = 2'h2
    } reset_state_t;
endpackage

// ### logic/dual_fir_config_registers.sv
// Configuration registers, field decode and coefficient store of a dual FIR
`timescale 1ns/1ns
`default_nettype none
`include "fir_cfg.svh"

// How it works
// - Bits 3:0 of the structure register hold n, giving decimate by n+1 and delay n+1.
// - Bit 4 of the structure register selects cascaded single (0) or dual (1) filters.
// - Bit 5 of the structure register selects even (0) or odd (1) symmetric coefficients.
// - Bits 6 and 7 set tap parity for filters A and B, zero odd and one even.
// - In dual mode bit 8 feeds filter B from the primary input (0) or its own input (1).
// - Bit 9 of the structure register selects interleaved coefficient sets when one.
// - Bits 0 and 1 of the format register give filter A data and coefficient formats.
// - Bits 2 and 3 of the format register give filter B data and coefficient formats.
// - Format bit 4 controls reversal of data order ahead of the reverse path.
// - Format bits 8:5 pick the output bit position where rounding is applied.
// - Format bit 9 turns rounding on or off, passing full precision when off.
// - Thirty-two coefficient sets are stored and the selected set feeds both filters.
// - A strobe rising edge loads the data bus into register 0 or 1 by address 000H or 001H.
// - Each configuration write starts an internal reset of six clocks, sparing coefficients.
// - Reversal and rounding are enabled by a zero in their control bits.
// - Each of format bits 3:0 reads zero as unsigned and one as two's complement.
module dual_fir_config_registers
    import fir_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Host write port, strobe active low
    input wire logic write_strobe_b_in,
    input wire fir_pkg::cfg_addr_t config_write_addr_in,
    input wire fir_pkg::cfg_word_t config_write_bus_in,
    input wire fir_pkg::coef_sel_t coef_select_in,
    // Datapath controls
    output logic internal_reset_out,
    output logic [3:0] decim_code_out,
    output logic [4:0] decim_delay_out,
    output logic dual_mode_out,
    output logic odd_symmetric_out,
    output logic even_taps_a_out,
    output logic even_taps_b_out,
    output logic b_from_secondary_out,
    output logic interleaved_out,
    output logic a_data_signed_out,
    output logic a_coef_signed_out,
    output logic b_data_signed_out,
    output logic b_coef_signed_out,
    output logic reversal_enable_out,
    output logic [3:0] round_position_out,
    output logic round_enable_out,
    output fir_pkg::coef_set_t coef_a_out,
    output fir_pkg::coef_set_t coef_b_out
);
    import fir_pkg::*;

    // ****************************************
    // Strobe edge detection
    // ****************************************
    // Strobe is taken synchronous to the clock; its rising edge commits.
    logic strobe_reg;
    logic write_edge;
    cfg_word_t filter_structure_config_reg;
    cfg_word_t format_rounding_config_reg;
    cfg_word_t structure_live_reg;
    cfg_word_t format_live_reg;
    reset_state_t state_reg;
    logic [2:0] hold_count_reg;
    logic cfg_write;
    logic [9:0] bank_a_reg [0:`COEF_SETS*`COEF_PER_SET/2-1];
    logic [9:0] bank_b_reg [0:`COEF_SETS*`COEF_PER_SET/2-1];

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            strobe_reg <= 1'b1;
        else
            strobe_reg <= write_strobe_b_in;
    end

    assign write_edge = write_strobe_b_in && !strobe_reg;

    function automatic logic is_cfg_addr(input cfg_addr_t a);
    begin
        is_cfg_addr = (a == `ADDR_STRUCT) || (a == `ADDR_FORMAT);
    end
    endfunction

    // Coefficient word: set number above bank number
    function automatic logic [6:0] coef_index(input cfg_addr_t a);
    begin
        coef_index = {a[`ADDR_SET_LSB +: 5], a[`ADDR_BANK_LSB +: 2]};
    end
    endfunction

    assign cfg_write = write_edge && is_cfg_addr(config_write_addr_in);

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            filter_structure_config_reg <= `CFG_RESET_VAL;
            format_rounding_config_reg <= `CFG_RESET_VAL;
        end
        else if (write_edge)
        begin
            // Other low addresses are reserved; writes to them are ignored
            if (config_write_addr_in == `ADDR_STRUCT)
                filter_structure_config_reg <= config_write_bus_in;
            else if (config_write_addr_in == `ADDR_FORMAT)
                format_rounding_config_reg <= config_write_bus_in;
        end
    end

    // ****************************************
    // Write-triggered internal reset
    // ****************************************
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg <= RUN_ST;
            hold_count_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                RUN_ST:
                begin
                    if (cfg_write)
                    begin
                        state_reg <= HOLD_ST;
                        hold_count_reg <= `INT_RESET_CYCLES - 3'h1;
                    end
                end
                HOLD_ST:
                begin
                    // A fresh write restarts the full six clocks
                    // Five down to zero keeps the reset high six clocks
                    if (cfg_write)
                        hold_count_reg <= `INT_RESET_CYCLES - 3'h1;
                    else if (hold_count_reg == 3'h0)
                        state_reg <= RUN_ST;
                    else
                        hold_count_reg <= hold_count_reg - 3'h1;
                end
                default:
                    state_reg <= RUN_ST;
            endcase
        end
    end

    assign internal_reset_out = (state_reg == HOLD_ST);

    // Fields reach the datapath only after the reset window closes
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            structure_live_reg <= `CFG_RESET_VAL;
            format_live_reg <= `CFG_RESET_VAL;
        end
        else if (state_reg == HOLD_ST && hold_count_reg == 3'h0 && !cfg_write)
        begin
            structure_live_reg <= filter_structure_config_reg;
            format_live_reg <= format_rounding_config_reg;
        end
    end

    // ****************************************
    // Field decode
    // ****************************************
    assign decim_code_out = structure_live_reg[`F0_DECIM_LSB +: 4];
    assign decim_delay_out = {1'b0, decim_code_out} + 5'h01;
    assign dual_mode_out = structure_live_reg[`F0_DUAL];
    assign odd_symmetric_out = structure_live_reg[`F0_ODD_SYM];
    assign even_taps_a_out = structure_live_reg[`F0_EVEN_A];
    assign even_taps_b_out = structure_live_reg[`F0_EVEN_B];
    // Source choice only meaningful in dual mode
    assign b_from_secondary_out = dual_mode_out
        && structure_live_reg[`F0_B_OWN_IN];
    assign interleaved_out = structure_live_reg[`F0_INTERLEAVE];
    assign a_data_signed_out = format_live_reg[`F1_A_DATA_TC];
    assign a_coef_signed_out = format_live_reg[`F1_A_COEF_TC];
    assign b_data_signed_out = format_live_reg[`F1_B_DATA_TC];
    assign b_coef_signed_out = format_live_reg[`F1_B_COEF_TC];
    assign reversal_enable_out = !format_live_reg[`F1_REV_DIS];
    assign round_position_out = format_live_reg[`F1_ROUND_LSB +: 4];
    assign round_enable_out = !format_live_reg[`F1_ROUND_DIS];

    // ****************************************
    // Coefficient store
    // ****************************************
    // Address bit 8 set marks a coefficient: bits 1:0 bank, 2 filter,
    // 7:3 set. Not cleared by the write reset.
    // No reset at all: contents are unknown until the host loads them.
    always_ff @(posedge clock_in)
    begin
        if (write_edge && config_write_addr_in[`ADDR_COEF_FLAG])
        begin
            if (config_write_addr_in[`ADDR_FILTER_BIT])
                bank_b_reg[coef_index(config_write_addr_in)]
                    <= config_write_bus_in;
            else
                bank_a_reg[coef_index(config_write_addr_in)]
                    <= config_write_bus_in;
        end
    end

    // Symmetric taps share four banks; eight values are the set's pairs
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            coef_a_out <= '0;
            coef_b_out <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                coef_a_out[i*10 +: 10] <= bank_a_reg[{coef_select_in, 2'(i)}];
                coef_b_out[i*10 +: 10] <= bank_b_reg[{coef_select_in, 2'(i)}];
                coef_a_out[40+i*10 +: 10] <= bank_a_reg[{coef_select_in, 2'(i)}];
                coef_b_out[40+i*10 +: 10] <= bank_b_reg[{coef_select_in, 2'(i)}];
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence cfg_wr_s;
        cfg_write && state_reg == RUN_ST;
    endsequence

    sequence hold_six_s;
        internal_reset_out [*6];
    endsequence

    sequence quiet_six_s;
        !cfg_write [*6];
    endsequence

    // Start and end are split so a restart inside the window stays legal
    reset_length_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        cfg_wr_s |=> hold_six_s)
        else $error("internal reset not six clocks");

    reset_end_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        cfg_wr_s ##1 quiet_six_s |=> !internal_reset_out)
        else $error("internal reset longer than six clocks");

    other_write_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        write_edge && !is_cfg_addr(config_write_addr_in) && !internal_reset_out
        |=> !internal_reset_out)
        else $error("reset after non-register write");

    count_range_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        internal_reset_out |-> hold_count_reg < `INT_RESET_CYCLES)
        else $error("reset counter out of range");

    reg0_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        write_edge && config_write_addr_in == `ADDR_STRUCT |=>
        filter_structure_config_reg == $past(config_write_bus_in))
        else $error("register 0 not loaded");

    reg1_write_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        write_edge && config_write_addr_in == `ADDR_FORMAT |=>
        format_rounding_config_reg == $past(config_write_bus_in))
        else $error("register 1 not loaded");

    reg_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !write_edge |=> $stable(filter_structure_config_reg)
        && $stable(format_rounding_config_reg))
        else $error("register changed without write");

    live_stable_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        internal_reset_out && $past(internal_reset_out)
        |-> $stable(structure_live_reg) && $stable(format_live_reg))
        else $error("fields changed inside reset");

    live_load_a: assert property (
        @(posedge clock_in) disable iff (!rst_b_in)
        $fell(internal_reset_out)
        |-> structure_live_reg == filter_structure_config_reg
        && format_live_reg == format_rounding_config_reg)
        else $error("fields not applied after reset");

    decim_delay_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        decim_delay_out == 5'(structure_live_reg[3:0]) + 5'h01)
        else $error("delay not code plus one");

    reversal_pol_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        reversal_enable_out != format_live_reg[4]
        && round_enable_out != format_live_reg[9])
        else $error("enable polarity wrong");

    b_source_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !structure_live_reg[4] |-> !b_from_secondary_out)
        else $error("source select outside dual mode");
endmodule
`default_nettype wire

// ### bench/host_model.sv
// Host model that writes configuration words through the strobe port
`timescale 1ns/1ns
`default_nettype none
module host_model
    import fir_pkg::*;
(
    // Clock and command
    input wire logic clock_in,
    input wire logic req_in,
    input wire fir_pkg::cfg_addr_t addr_in,
    input wire fir_pkg::cfg_word_t data_in,
    // Write port
    output logic write_strobe_b_out,
    output fir_pkg::cfg_addr_t config_write_addr_out,
    output fir_pkg::cfg_word_t config_write_bus_out
);
    import fir_pkg::*;
    // ****************
    // Strobe sequencer
    // ****************
    logic [1:0] step_reg = 2'h0;
    initial
    begin
        write_strobe_b_out = 1'h1;
        config_write_addr_out = 9'h000;
        config_write_bus_out = 10'h000;
    end
    // Low one clock, high one clock, then the bus is let go
    always @(negedge clock_in)
    begin
        case (step_reg)
            2'h0:
            begin
                if (req_in)
                begin
                    write_strobe_b_out <= 1'h0;
                    config_write_addr_out <= addr_in;
                    config_write_bus_out <= data_in;
                    step_reg <= 2'h1;
                end
            end
            2'h1:
            begin
                write_strobe_b_out <= 1'h1;
                step_reg <= 2'h2;
            end
            default:
            begin
                // Released bus must not keep the last word
                config_write_bus_out <= ~config_write_bus_out;
                step_reg <= 2'h0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fir_pkg::*;
    // ****************
    // Stimulus and model state
    // ****************
    logic clock_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic req = 1'h0;
    logic chk = 1'h0;
    cfg_addr_t h_addr = 9'h000;
    cfg_word_t h_data = 10'h000;
    coef_sel_t sel = 5'h00;
    cfg_word_t r0m = 10'h000;
    cfg_word_t r1m = 10'h000;
    cfg_word_t cmem [0:1][0:31][0:3];
    logic [15:0] lf = 16'h001E;
    logic [184:0] exp_q [$];
    int hi_cnt = 0;
    int n_mismatch = 0;
    int n_checks = 0;
    wire logic strobe_b;
    wire cfg_addr_t w_addr;
    wire cfg_word_t w_data;
    wire logic irst;
    wire logic [184:0] obs;
    always #20 clock_in = ~clock_in;
    host_model i_host (.clock_in(clock_in), .req_in(req), .addr_in(h_addr),
        .data_in(h_data), .write_strobe_b_out(strobe_b),
        .config_write_addr_out(w_addr), .config_write_bus_out(w_data));
    dual_fir_config_registers i_dut (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .write_strobe_b_in(strobe_b),
        .config_write_addr_in(w_addr), .config_write_bus_in(w_data),
        .coef_select_in(sel), .internal_reset_out(irst),
        .decim_code_out(obs[184:181]), .decim_delay_out(obs[180:176]),
        .dual_mode_out(obs[175]), .odd_symmetric_out(obs[174]),
        .even_taps_a_out(obs[173]), .even_taps_b_out(obs[172]),
        .b_from_secondary_out(obs[171]), .interleaved_out(obs[170]),
        .a_data_signed_out(obs[169]), .a_coef_signed_out(obs[168]),
        .b_data_signed_out(obs[167]), .b_coef_signed_out(obs[166]),
        .reversal_enable_out(obs[165]), .round_position_out(obs[164:161]),
        .round_enable_out(obs[160]), .coef_a_out(obs[159:80]),
        .coef_b_out(obs[79:0]));
    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] lfsr_step(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [184:0] exp_snap(cfg_word_t a, cfg_word_t b);
        logic [39:0] ca;
        logic [39:0] cb;
        ca = {cmem[0][sel][3], cmem[0][sel][2], cmem[0][sel][1], cmem[0][sel][0]};
        cb = {cmem[1][sel][3], cmem[1][sel][2], cmem[1][sel][1], cmem[1][sel][0]};
        return {a[3:0], 5'(a[3:0]) + 5'h01, a[4], a[5], a[6], a[7],
            a[8] & a[4], a[9], b[0], b[1], b[2], b[3], ~b[4], b[8:5], ~b[9],
            ca, ca, cb, cb};
    endfunction
    task automatic cmp(logic [184:0] got, logic [184:0] want);
        n_checks++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic host_write(cfg_addr_t a, cfg_word_t d);
        @(negedge clock_in);
        req <= 1'h1;
        h_addr <= a;
        h_data <= d;
        @(negedge clock_in);
        req <= 1'h0;
        repeat (3) @(negedge clock_in);
    endtask
    // Expectation goes in before the write so the monitor finds it
    task automatic cfg_write(logic one, cfg_word_t d);
        int k;
        if (one)
            r1m = d;
        else
            r0m = d;
        exp_q.push_back(exp_snap(r0m, r1m));
        host_write({8'h00, one}, d);
        k = 0;
        while (irst === 1'h1 && k < 20)
        begin
            @(negedge clock_in);
            k++;
        end
    endtask
    task automatic check_now();
        exp_q.push_back(exp_snap(r0m, r1m));
        @(negedge clock_in);
        chk <= 1'h1;
        @(negedge clock_in);
        chk <= 1'h0;
    endtask
    task automatic test_done();
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************
    // Monitor: reset length and results at the end of each window
    // ****************
    always @(negedge clock_in)
    begin
        if (irst === 1'h1)
            hi_cnt++;
        else if (hi_cnt != 0 || chk)
        begin
            if (hi_cnt != 0)
                cmp(185'(hi_cnt), 185'h6);
            hi_cnt = 0;
            if (exp_q.size() == 0)
                cmp(185'(exp_q.size()), 185'h1);
            else
                cmp(obs, exp_q.pop_front());
        end
    end
    initial
    begin
        #(40 * 4000);
        n_mismatch++;
        test_done();
    end
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        foreach (cmem[f, s, b])
            cmem[f][s][b] = 10'h000;
        repeat (3) @(negedge clock_in);
        rst_b_in = 1'h1;
        // Set 0 is shown from the start, so give it known contents
        for (int i = 0; i < 8; i++)
            host_write({1'h1, 5'h00, i[2:0]}, 10'h000);
        check_now();
        for (int i = 0; i < 16; i++)
        begin
            lf = lfsr_step(lf);
            cfg_write(1'h0, {lf[5:0], 4'(i)});
            lf = lfsr_step(lf);
            cfg_write(1'h1, lf[9:0]);
        end
        host_write(9'h002, lf[9:0]);
        host_write(9'h0FF, ~lf[9:0]);
        repeat (8) @(negedge clock_in);
        check_now();
        for (int i = 0; i < 16; i++)
        begin
            lf = lfsr_step(lf);
            cmem[i[2]][i[3] ? 31 : 0][i[1:0]] = lf[9:0];
            host_write({1'h1, i[3] ? 5'h1F : 5'h00, i[2], i[1:0]}, lf[9:0]);
        end
        sel <= 5'h1F;
        repeat (3) @(negedge clock_in);
        check_now();
        cfg_write(1'h0, 10'h3FF);
        sel <= 5'h00;
        repeat (3) @(negedge clock_in);
        check_now();
        // Mid-run reset: fields clear, coefficient banks survive
        @(negedge clock_in);
        rst_b_in = 1'h0;
        @(negedge clock_in);
        rst_b_in = 1'h1;
        r0m = 10'h000;
        r1m = 10'h000;
        check_now();
        // Let the monitor take the last result first
        repeat (2) @(negedge clock_in);
        test_done();
    end
endmodule
`default_nettype wire
